/* logic/logic_cell_group.sv */
// Group of ten programmable logic cells with carry, cascade and AXI4-Lite setup
//
// Function
// - Ten cells share carry, cascade, group control lines and local inputs.
// - Each cell has a four-input lookup and a programmable register.
// - Carry input feeds the cell lookup and the next carry stage.
// - First cell of the group takes no part in the carry chain.
// - First cell inputs may produce group synchronous clear and load.
// - Chains over nine cells continue into the group two positions ahead.
// - Chain ends at the mid-row group; the next group starts fresh.
// - n-bit adder uses n+1 cells; sum registered or combinational.
// - Normal mode: lookup of three data plus carry or fourth; cascade combine.
// - Arithmetic mode: two three-input lookups give result and carry out.
// - Arithmetic mode may use the cascade chain together with carry.
// - Counter enable or up/down from one local input; clear, load group-wide.
// - Counter: data and carry lookups, load multiplexer, clear AND gate.
// - Clear beats load; both override the data lookup value in counters.
// - Load may act as enable by reloading the register's own output.
// - Second cell carry input may come from its own register output.
// - Emulated bus: several enables give low, no enable gives high.
// - Either control line may drive clear or preset; unused tied high.
// - Preset is the clear with register input and output inverted.
// - Optional chip-wide reset overrides all; it clears every register, or presets it in preset mode.
`timescale 1ns/1ns
module logic_cell_group
   import cell_group_pkg::*;
#(
   parameter int CELLS = NUM_CELLS
) (
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Local interconnect data, bit i feeds cell i
   input wire logic [CELLS-1:0] first_data_input,
   input wire logic [CELLS-1:0] second_data_input,
   input wire logic [CELLS-1:0] third_data_input,
   input wire logic [CELLS-1:0] fourth_data_input,
   // Chains from neighbouring groups
   input wire logic group_carry_in,
   input wire logic group_cascade_in,
   // Group control lines and chip-wide reset, active low, from pins
   input wire logic group_control_line_a,
   input wire logic group_control_line_b,
   input wire logic chip_wide_reset_n,
   // Results
   output logic [CELLS-1:0] cell_out,
   output logic group_carry_out,
   output logic group_cascade_out,
   output logic emulated_bus_out
);

   // Lookup selection, shared by every mode
   function automatic logic lut_pick(input logic [LUT_BITS-1:0] mask, input logic [3:0] idx);
      lut_pick = mask[idx];
   endfunction

   // Emulated three-state bus: one driver passes, contention low, float high
   function automatic logic bus_resolve(input logic [CELLS-1:0] oe, input logic [CELLS-1:0] val);
      logic [CELLS-1:0] others;
      others = oe & (oe - CELLS'(1));
      if (oe == '0) begin
         bus_resolve = 1'b1;
      end else if (others != '0) begin
         bus_resolve = 1'b0;
      end else begin
         bus_resolve = |(oe & val);
      end
   endfunction

   // Configuration and state
   logic [CTRL_WIDTH-1:0] group_ctrl;
   logic [CELLS-1:0] bus_enable;
   logic [CFG_WIDTH-1:0] cell_cfg [CELLS];
   logic [CELLS-1:0] cell_state;
   logic [CELLS-1:0] next_state;

   // Pin synchronisers; the first stage feeds only the second
   logic [2:0] pin_meta;
   logic [2:0] pin_sync;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta <= 3'h7;
         pin_sync <= 3'h7;
      end else begin
         pin_meta <= {chip_wide_reset_n, group_control_line_b, group_control_line_a};
         pin_sync <= pin_meta;
      end
   end

   wire line_a_n = pin_sync[0];
   wire line_b_n = pin_sync[1];
   wire chip_reset_act = group_ctrl[CTRL_CHIP_RESET_USE_BIT] & ~pin_sync[2];

   // Group-wide synchronous controls come from the first cell's inputs
   wire sync_use = group_ctrl[CTRL_SYNC_CONTROL_USE_BIT];
   wire sync_clear = sync_use & first_data_input[0];
   wire sync_load = sync_use & second_data_input[0];

   // Chain wiring between cells
   logic [CELLS-1:0] carry_in;
   logic [CELLS-1:0] carry_out;
   logic [CELLS:0] cascade;
   logic [CELLS-1:0] comb_out;
   logic [CELLS-1:0] cell_value;
   logic [CELLS-1:0] register_q;

   assign cascade[0] = group_cascade_in;
   assign carry_in[0] = 1'b0;
   // Second cell starts the chain from the far group or its own register
   assign carry_in[1] = group_ctrl[CTRL_FAST_FEEDBACK_BIT] ? register_q[1] : group_carry_in;

   genvar gi;
   generate
      for (gi = 0; gi < CELLS; gi++) begin : g_cell
         wire [LUT_BITS-1:0] mask = cell_cfg[gi][CFG_LUT_LSB +: LUT_BITS];
         wire [1:0] mode = cell_cfg[gi][CFG_MODE_LSB +: 2];
         wire is_counter = (mode == MODE_COUNTER);
         wire is_arith = (mode == MODE_ARITHMETIC);
         wire preset_mode = cell_cfg[gi][CFG_PRESET_MODE_BIT];
         // Lookup inputs per mode
         wire fourth_or_carry = cell_cfg[gi][CFG_CARRY_SELECT_BIT] ?
            carry_in[gi] : fourth_data_input[gi];
         wire [3:0] idx_normal = {fourth_or_carry, third_data_input[gi],
            second_data_input[gi], first_data_input[gi]};
         wire [2:0] idx_arith = {carry_in[gi], second_data_input[gi],
            first_data_input[gi]};
         // Third input is the lone count control: enable or up/down as the mask decides
         wire [2:0] idx_count = {third_data_input[gi], carry_in[gi], register_q[gi]};
         wire [2:0] idx3 = is_counter ? idx_count : idx_arith;
         wire lut4_out = lut_pick(mask, idx_normal);
         wire lut_data = lut_pick(mask, {1'b0, idx3});
         wire lut_carry = lut_pick(mask, {1'b1, idx3});
         wire mode_out = (mode == MODE_NORMAL) ? lut4_out : lut_data;
         // Cascade joins in every mode but counter
         wire cascaded = cell_cfg[gi][CFG_CASCADE_USE_BIT] ?
            (mode_out & cascade[gi]) : mode_out;
         wire base_data = is_counter ? lut_data : cascaded;
         wire load_data = cell_cfg[gi][CFG_LOAD_SELF_BIT] ?
            register_q[gi] : fourth_data_input[gi];
         wire loaded = sync_load ? load_data : base_data;
         wire reg_data = ~sync_clear & loaded;
         // Clear from the chosen line, only when the cell uses one
         wire line_n = cell_cfg[gi][CFG_CLEAR_SOURCE_BIT] ? line_b_n : line_a_n;
         wire clear_act = cell_cfg[gi][CFG_CLEAR_USE_BIT] & ~line_n;

         assign register_q[gi] = preset_mode ? ~cell_state[gi] : cell_state[gi];
         assign comb_out[gi] = cascaded;
         assign cascade[gi+1] = cascaded;
         assign carry_out[gi] = (is_arith | is_counter) & lut_carry;
         assign cell_value[gi] = (cell_cfg[gi][CFG_REGISTERED_BIT] | is_counter) ?
            register_q[gi] : comb_out[gi];

         // Reset first, then clear, otherwise the register loads
         always_comb begin
            if (chip_reset_act | clear_act) begin
               next_state[gi] = 1'b0;
            end else begin
               next_state[gi] = preset_mode ? ~reg_data : reg_data;
            end
         end

         if (gi >= 2) begin : g_chain
            assign carry_in[gi] = carry_out[gi-1];
         end
      end
   endgenerate

   // Last cell carries out unless this group closes the row half
   wire chain_out = carry_out[CELLS-1] & ~group_ctrl[CTRL_MID_ROW_END_BIT];
   wire bus_value = bus_resolve(bus_enable, cell_value);

   // Cell registers and registered outputs; combinational results gain one stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cell_state <= '0;
         cell_out <= '0;
         group_carry_out <= 1'b0;
         group_cascade_out <= 1'b0;
         emulated_bus_out <= 1'b1;
      end else begin
         cell_state <= next_state;
         cell_out <= cell_value;
         group_carry_out <= chain_out;
         group_cascade_out <= cascade[CELLS];
         emulated_bus_out <= bus_value;
      end
   end

   // Write channel: address and data taken in either order, answered together
   logic aw_full;
   logic w_full;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire write_fire = aw_full & w_full & ~s_axi_bvalid;
   wire next_aw_full = write_fire ? 1'b0 : (aw_full | aw_take);
   wire next_w_full = write_fire ? 1'b0 : (w_full | w_take);

   // Address decode shared by both channels
   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a == GROUP_CTRL_OFFSET) || (a == BUS_ENABLE_OFFSET) ||
         (a == GROUP_STATUS_OFFSET) ||
         ((a >= CELL_CFG_BASE) && (a <= CELL_CFG_LAST) && (a[1:0] == 2'h0));
   endfunction

   wire [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire [3:0] w_cell = 4'((aw_addr - CELL_CFG_BASE) >> 2);
   wire w_is_cell = (aw_addr >= CELL_CFG_BASE) && (aw_addr <= CELL_CFG_LAST);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
      end else begin
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         s_axi_awready <= ~next_aw_full;
         s_axi_wready <= ~next_w_full;
         if (aw_take) begin
            aw_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (write_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register file writes; status is read only
   wire [31:0] ctrl_word = {{(32-CTRL_WIDTH){1'b0}}, group_ctrl};
   wire [31:0] bus_word = {{(32-CELLS){1'b0}}, bus_enable};
   wire [31:0] ctrl_merge = (ctrl_word & ~strb_mask) | (w_data & strb_mask);
   wire [31:0] bus_merge = (bus_word & ~strb_mask) | (w_data & strb_mask);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         group_ctrl <= GROUP_CTRL_RESET;
         bus_enable <= BUS_ENABLE_RESET;
         for (int i = 0; i < CELLS; i++) begin
            cell_cfg[i] <= CELL_CFG_RESET;
         end
      end else if (write_fire) begin
         if (aw_addr == GROUP_CTRL_OFFSET) begin
            group_ctrl <= ctrl_merge[CTRL_WIDTH-1:0];
         end
         if (aw_addr == BUS_ENABLE_OFFSET) begin
            bus_enable <= bus_merge[CELLS-1:0];
         end
         for (int i = 0; i < CELLS; i++) begin
            if (w_is_cell && (aw_addr[1:0] == 2'h0) && (w_cell == 4'(i))) begin
               cell_cfg[i] <= ((cell_cfg[i] & ~strb_mask[CFG_WIDTH-1:0]) |
                  (w_data[CFG_WIDTH-1:0] & strb_mask[CFG_WIDTH-1:0]));
            end
         end
      end
   end

   // Read channel: one read at a time, data one cycle after the address
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire [3:0] r_cell = 4'((s_axi_araddr - CELL_CFG_BASE) >> 2);
   wire r_is_cell = (s_axi_araddr >= CELL_CFG_BASE) && (s_axi_araddr <= CELL_CFG_LAST);
   wire [31:0] status_word = {19'h00000, cascade[CELLS],
      chain_out, bus_value, cell_value};
   wire [31:0] cfg_word = (r_is_cell && r_cell < 4'(CELLS)) ?
      {{(32-CFG_WIDTH){1'b0}}, cell_cfg[r_cell]} : 32'h00000000;

   logic [31:0] read_word;
   always_comb begin
      if (!addr_mapped(s_axi_araddr)) begin
         read_word = 32'h00000000;
      end else if (s_axi_araddr == GROUP_CTRL_OFFSET) begin
         read_word = ctrl_word;
      end else if (s_axi_araddr == BUS_ENABLE_OFFSET) begin
         read_word = bus_word;
      end else if (s_axi_araddr == GROUP_STATUS_OFFSET) begin
         read_word = status_word;
      end else begin
         read_word = cfg_word;
      end
   end

   wire next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~next_rvalid;
         s_axi_rvalid <= next_rvalid;
         if (ar_take) begin
            s_axi_rdata <= read_word;
            s_axi_rresp <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

endmodule // logic_cell_group

/* logic/cell_group_pkg.sv */
// Constants, register map and field layout for the logic cell group
package cell_group_pkg;
   // Group shape
   localparam int NUM_CELLS = 10;
   localparam int LUT_BITS = 16;
   localparam int HALF_LUT_BITS = 8;

   // Register byte offsets
   localparam logic [7:0] GROUP_CTRL_OFFSET = 8'h00;
   localparam logic [7:0] BUS_ENABLE_OFFSET = 8'h04;
   localparam logic [7:0] GROUP_STATUS_OFFSET = 8'h08;
   localparam logic [7:0] CELL_CFG_BASE = 8'h40;
   localparam logic [7:0] CELL_CFG_LAST = 8'h64;

   // Group control fields
   localparam int CTRL_CHIP_RESET_USE_BIT = 0;
   localparam int CTRL_SYNC_CONTROL_USE_BIT = 1;
   localparam int CTRL_MID_ROW_END_BIT = 2;
   localparam int CTRL_FAST_FEEDBACK_BIT = 3;
   localparam int CTRL_WIDTH = 4;

   // Cell configuration fields
   localparam int CFG_LUT_LSB = 0;
   localparam int CFG_MODE_LSB = 16;
   localparam int CFG_CARRY_SELECT_BIT = 18;
   localparam int CFG_REGISTERED_BIT = 19;
   localparam int CFG_CASCADE_USE_BIT = 20;
   localparam int CFG_CLEAR_SOURCE_BIT = 21;
   localparam int CFG_PRESET_MODE_BIT = 22;
   localparam int CFG_CLEAR_USE_BIT = 23;
   localparam int CFG_LOAD_SELF_BIT = 24;
   localparam int CFG_WIDTH = 25;

   // Mode field codes
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_ARITHMETIC = 2'h1;
   localparam logic [1:0] MODE_COUNTER = 2'h2;

   // Status fields
   localparam int STAT_CELL_LSB = 0;
   localparam int STAT_BUS_BIT = 10;
   localparam int STAT_CARRY_BIT = 11;
   localparam int STAT_CASCADE_BIT = 12;

   // Reset values
   localparam logic [CTRL_WIDTH-1:0] GROUP_CTRL_RESET = 4'h0;
   localparam logic [NUM_CELLS-1:0] BUS_ENABLE_RESET = 10'h000;
   localparam logic [CFG_WIDTH-1:0] CELL_CFG_RESET = 25'h0000000;

   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* tb/cell_group_properties.sv */
// Bus, reset and carry-end properties of the logic cell group
`timescale 1ns/1ns
module cell_group_properties
   import cell_group_pkg::*;
#(
   parameter int CELLS = NUM_CELLS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [CELLS-1:0] cell_out,
   input wire logic group_carry_out,
   input wire logic emulated_bus_out
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Handshakes and address decode seen from the pins
   wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire rd_go = s_axi_arvalid && s_axi_arready;
   wire bad_rd = s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > CELL_CFG_LAST
      || (s_axi_araddr > GROUP_STATUS_OFFSET && s_axi_araddr < CELL_CFG_BASE);
   logic [3:0] ctrl_q;
   // Shadow of the control word, since the carry rule depends on it
   always_ff @(posedge aclk) begin
      if (!aresetn) ctrl_q <= 4'h0;
      else if (wr_go && s_axi_awaddr == GROUP_CTRL_OFFSET) ctrl_q <= s_axi_wdata[3:0];
   end
   a_write_answer: assert property (wr_go |-> ##[1:2] s_axi_bvalid)
      else $error("write answer missing");
   a_read_answer: assert property (rd_go |=> s_axi_rvalid)
      else $error("read answer missing");
   a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while answer pending");
   a_aw_single: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("second write address taken");
   a_bad_read: assert property (rd_go && bad_rd |=>
      s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read answered");
   a_reset_values: assert property ($rose(aresetn) |->
      cell_out == '0 && emulated_bus_out && !s_axi_bvalid) else $error("reset values wrong");
   a_mid_row_end: assert property (ctrl_q[2] && $past(ctrl_q[2], 3) |->
      !group_carry_out) else $error("carry crossed row middle");
   c_write: cover property (wr_go);
   c_bad_read: cover property (rd_go && bad_rd);
   c_row_end: cover property (ctrl_q[2] && $past(ctrl_q[2], 3));
endmodule // cell_group_properties

bind logic_cell_group cell_group_properties #(.CELLS(CELLS)) chk_u (.*);

/* tb/tb.sv */
// Self-checking bench for the logic cell group
`timescale 1ns/1ns
module tb;
   import cell_group_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, carry_out, casc_out, bus_out;
   logic [1:0] bresp, rresp;
   logic [9:0] d1 = 10'h000, d2 = 10'h000, d3 = 10'h000, d4 = 10'h000, cell_out;
   logic cin = 1'b0, ctl_a = 1'b1, ctl_b = 1'b1, chip_n = 1'b1, casc_in = 1'b0;
   int fails = 0;
   int comparisons = 0;

   logic_cell_group #(.CELLS(10)) dut_u (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .first_data_input(d1), .second_data_input(d2), .third_data_input(d3),
      .fourth_data_input(d4), .group_carry_in(cin), .group_cascade_in(casc_in),
      .group_control_line_a(ctl_a), .group_control_line_b(ctl_b), .chip_wide_reset_n(chip_n),
      .cell_out(cell_out), .group_carry_out(carry_out), .group_cascade_out(casc_out),
      .emulated_bus_out(bus_out)
   );

   // Free-running 100 MHz clock
   initial begin
      forever #5 aclk = ~aclk;
   end

   task automatic test_done();
      if (fails == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // A wait that ran out ends the run at once
   task automatic guard(input int n);
      if (n >= 50) begin
         fails++;
         test_done();
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Answer ready goes up with the request and stays up until the answer is seen
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 50);
      bready <= 1'b0;
      guard(n);
      chk(32'(bresp), 32'(er));
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q, input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 50);
      q = rdata;
      rready <= 1'b0;
      guard(n);
      chk(32'(rresp), 32'(er));
      @(posedge aclk);
   endtask

   task automatic cfg(input int i, input logic [31:0] d);
      wr(8'(CELL_CFG_BASE + 4 * i), d, RESP_OKAY);
   endtask

   task automatic regs_and_refusals();
      rd(GROUP_CTRL_OFFSET, v, RESP_OKAY);
      chk(v, 32'h0);
      rd(CELL_CFG_LAST, v, RESP_OKAY);
      chk(v, 32'h0);
      rd(8'h30, v, RESP_SLVERR);
      chk(v, 32'h0);
      rd(8'h41, v, RESP_SLVERR);
      wr(8'h68, 32'hFFFF, RESP_SLVERR);
      wr(GROUP_STATUS_OFFSET, 32'h3FF, RESP_OKAY);
      rd(GROUP_STATUS_OFFSET, v, RESP_OKAY);
      chk(v & 32'h7FF, 32'h400);
   endtask

   task automatic lookup_and_bus();
      logic [15:0] m = 16'h6996;
      logic [9:0] en [5] = '{10'h001, 10'h002, 10'h000, 10'h005, 10'h004};
      logic ex [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      for (int i = 0; i < 10; i++) cfg(i, 32'(m));
      for (int k = 0; k < 16; k++) begin
         d1 <= {10{k[0]}};
         d2 <= {10{k[1]}};
         d3 <= {10{k[2]}};
         d4 <= {10{k[3]}};
         tick(3);
         chk(32'(cell_out), 32'({10{m[k]}}));
      end
      // Cells 0 and 2 read one, all others zero
      d1 <= 10'h005;
      {d2, d3, d4} <= 30'h0;
      for (int k = 0; k < 5; k++) begin
         wr(BUS_ENABLE_OFFSET, 32'(en[k]), RESP_OKAY);
         tick(3);
         chk(32'(bus_out), 32'(ex[k]));
      end
   endtask

   task automatic adder_and_row_end();
      logic [7:0] a [3] = '{8'hFF, 8'hA5, 8'h3C};
      logic [7:0] b [3] = '{8'h01, 8'h5A, 8'h0F};
      logic c [3] = '{1'b0, 1'b1, 1'b0};
      logic [8:0] s;
      for (int i = 0; i < 9; i++) cfg(i, 32'({MODE_ARITHMETIC, 16'hE896}));
      cfg(9, 32'({1'b1, MODE_NORMAL, 16'hFF00}));
      // Cell 0 makes a carry that must not reach cell 1
      for (int k = 0; k < 3; k++) begin
         d1 <= {1'b0, a[k], 1'b1};
         d2 <= {1'b0, b[k], 1'b1};
         cin <= c[k];
         tick(4);
         s = 9'(a[k]) + 9'(b[k]) + 9'(c[k]);
         chk(32'(cell_out), 32'({s, 1'b0}));
      end
      cfg(9, 32'({MODE_ARITHMETIC, 16'hE800}));
      d1 <= 10'h200;
      d2 <= 10'h200;
      tick(4);
      chk(32'(carry_out), 32'h1);
      wr(GROUP_CTRL_OFFSET, 32'h4, RESP_OKAY);
      tick(4);
      chk(32'(carry_out), 32'h0);
   endtask

   task automatic clears_and_reset();
      logic [1:0] ex [6] = '{2'b01, 2'b00, 2'b01, 2'b11, 2'b10, 2'b01};
      logic [2:0] pin [6] = '{3'b111, 3'b011, 3'b111, 3'b101, 3'b110, 3'b110};
      cfg(5, 32'h0088FFFF);
      cfg(6, 32'h00E80000);
      wr(GROUP_CTRL_OFFSET, 32'h1, RESP_OKAY);
      // Pin patterns a, b, chip reset; the last runs with chip reset unused
      for (int k = 0; k < 6; k++) begin
         if (k == 5) wr(GROUP_CTRL_OFFSET, 32'h0, RESP_OKAY);
         {ctl_a, ctl_b, chip_n} <= pin[k];
         tick(6);
         chk(32'(cell_out[6:5]), 32'(ex[k]));
      end
      chip_n <= 1'b1;
   endtask

   task automatic counter_controls();
      // Cells outside the counter stay combinational
      for (int i = 0; i < 10; i++)
         cfg(i, (i >= 1 && i <= 4) ? 32'({MODE_COUNTER, 16'h806A}) : 32'h0);
      wr(GROUP_CTRL_OFFSET, 32'h2, RESP_OKAY);
      {cin, d1, d3} <= {1'b1, 20'h0};
      d2 <= 10'h001;
      d4 <= 10'h01A;
      tick(4);
      chk(32'(cell_out[4:1]), 32'hD);
      d1 <= 10'h001;
      tick(4);
      chk(32'(cell_out[4:1]), 32'h0);
      {d1, d2} <= 20'h0;
      tick(3);
      d3 <= 10'h01E;
      tick(3);
      d3 <= 10'h000;
      tick(4);
      chk(32'(cell_out[4:1]), 32'h3);
   endtask

   // Fast feedback, self reload, and cascade through normal and arithmetic cells
   task automatic chain_options();
      // With the carry pin low cell 1 would hold; its own register clears it
      cin <= 1'b0;
      d3 <= 10'h002;
      wr(GROUP_CTRL_OFFSET, 32'hA, RESP_OKAY);
      tick(4);
      chk(32'(cell_out[4:1]), 32'h2);
      cfg(2, 32'h0102806A);
      d4 <= 10'h018;
      d2 <= 10'h001;
      tick(4);
      chk(32'(cell_out[4:1]), 32'hE);
      d2 <= 10'h000;
      wr(GROUP_CTRL_OFFSET, 32'h0, RESP_OKAY);
      for (int i = 0; i < 10; i++) cfg(i, (i == 3) ? 32'h001100FF : 32'h0010FFFF);
      for (int k = 1; k >= 0; k--) begin
         casc_in <= k[0];
         tick(3);
         chk(32'({casc_out, cell_out}), 32'({11{k[0]}}));
      end
   endtask

   initial begin
      tick(2);
      aresetn <= 1'b1;
      tick(1);
      regs_and_refusals();
      lookup_and_bus();
      adder_and_row_end();
      clears_and_reset();
      counter_controls();
      chain_options();
      test_done();
   end
endmodule // tb
